// [rtl/mmsm_pkg.sv]
// Purpose: Types shared by the configuration block
// Assumes: Nothing beyond the register header
// Notes:   Encodings follow the field codes directly
package mmsm_pkg;

    // ------------------------------------------------------------
    // Field encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MMSM_MAC_SGMII  = 2'h0,
        MMSM_MAC_QSGMII = 2'h1,
        MMSM_MAC_RSV2   = 2'h2,
        MMSM_MAC_RSV3   = 2'h3
    } mmsm_mac_mode_type;

    typedef enum logic [1:0] {
        MMSM_SCL_50K  = 2'h0,
        MMSM_SCL_100K = 2'h1,
        MMSM_SCL_400K = 2'h2,
        MMSM_SCL_2M   = 2'h3
    } mmsm_scl_sel_type;

    // APB slave phases, Gray along idle->access->idle
    typedef enum logic [1:0] {
        MMSM_APB_IDLE   = 2'h0,
        MMSM_APB_ACCESS = 2'h1
    } mmsm_apb_state_type;

endpackage

// [rtl/mmsm_regs.svh]
// Purpose: Register offsets, field positions, resets and timing counts
// Assumes: APB byte addressing, one 32-bit word per register
// Notes:   Printed offsets are register indices; byte address is 4x
`ifndef MMSM_REGS_SVH
`define MMSM_REGS_SVH

// ------------------------------------------------------------
// Register indices and byte addresses
// ------------------------------------------------------------
`define MMSM_IDX_MACCFG      8'h13
`define MMSM_IDX_MUXSETUP    8'h14
`define MMSM_IDX_MUXCTRL     8'h15
`define MMSM_ADDR_MACCFG     12'h04c
`define MMSM_ADDR_MUXSETUP   12'h050
`define MMSM_ADDR_MUXCTRL    12'h054

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define MMSM_MACMODE_LSB     4'he
`define MMSM_FLSRC_LSB       4'h0
`define MMSM_DEVADDR_LSB     4'h9
`define MMSM_SCLSEL_LSB      4'h4
`define MMSM_PORTEN_LSB      4'h0
`define MMSM_DIR_LSB         4'h8

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define MMSM_MACMODE_RST     2'h0
`define MMSM_FLSRC_RST       4'hf
`define MMSM_DEVADDR_RST     7'h50
`define MMSM_SCLSEL_RST      2'h1
`define MMSM_PORTEN_RST      4'h0
`define MMSM_DIR_RST         1'h1

// ------------------------------------------------------------
// SCL timing: frequency in kHz, clock in kHz
// ------------------------------------------------------------
`define MMSM_CLK_KHZ         200000
`define MMSM_SCL_50_KHZ      50
`define MMSM_SCL_100_KHZ     100
`define MMSM_SCL_400_KHZ     400
`define MMSM_SCL_2000_KHZ    2000
// Half-period counts, rounded down so SCL never runs slow
`define MMSM_HALF_50         (`MMSM_CLK_KHZ / (2 * `MMSM_SCL_50_KHZ))
`define MMSM_HALF_100        (`MMSM_CLK_KHZ / (2 * `MMSM_SCL_100_KHZ))
`define MMSM_HALF_400        (`MMSM_CLK_KHZ / (2 * `MMSM_SCL_400_KHZ))
`define MMSM_HALF_2000       (`MMSM_CLK_KHZ / (2 * `MMSM_SCL_2000_KHZ))

`endif

// [rtl/mmsm_scl_div.sv]
// Purpose: Free-running SCL divider for the serial mux
// Assumes: Select is stable register output on the same clock
// Notes:   Count is compared live against the half-period; a new rate
//          applies to the phase in progress, so a change can cut it short or stretch it
`timescale 1ns/1ps
`include "mmsm_regs.svh"

module mmsm_scl_div #(
    parameter int CNT_W = 12
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    // Control
    input  wire logic [1:0]       i_sel,
    // Output
    output logic                  o_scl
);

    logic [CNT_W-1:0] half_cnt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic             scl_r;
    wire              wrap;

    // ------------------------------------------------------------
    // Rate select
    // ------------------------------------------------------------
    always_comb begin
        case (i_sel)
            2'h0:    half_cnt = CNT_W'(`MMSM_HALF_50 - 1);
            2'h1:    half_cnt = CNT_W'(`MMSM_HALF_100 - 1);
            2'h2:    half_cnt = CNT_W'(`MMSM_HALF_400 - 1);
            default: half_cnt = CNT_W'(`MMSM_HALF_2000 - 1);
        endcase
    end

    assign wrap    = (cnt_r >= half_cnt);
    assign cnt_nxt = wrap ? '0 : cnt_r + CNT_W'(1);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_r <= '0;
            scl_r <= 1'b1;
        end else begin
            cnt_r <= cnt_nxt;
            if (wrap) begin
                scl_r <= ~scl_r;
            end
        end
    end

    assign o_scl = scl_r;

endmodule

// [rtl/mmsm_top.sv]
// Purpose: MAC mode and serial mux configuration registers
// Assumes: APB master on I_MCLK; pin inputs are asynchronous
// Notes:   Pin outputs are registered; mux transactions live elsewhere
//
// Behaviour
// - MAC mode field: 00 SGMII, 01 QSGMII
// - Fail source: ports 0-3, 1100-1111 disable
// - Selected port failure drives shared pin
// - Seven-bit device address, default byte 0xA1
// - Direction 1 read, 0 write, reset read
// - SCL rate 50k/100k/400k/2M, reset 100k
// - Per-port enables; zero returns pin to GPIO
// - Serial LED forces mux port 0 GPIO
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "mmsm_regs.svh"

module mmsm_top (
    // Clock and reset
    input  wire logic        I_MCLK,
    input  wire logic        I_RST_B,
    // APB slave
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    input  wire logic [3:0]  I_PSTRB,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    // Port status pins
    input  wire logic [3:0]  I_PORT_LINK_FAIL,
    input  wire logic        I_SERIAL_LED_EN,
    // Shared fast link failure pin
    output logic             O_FAST_LINK_FAILURE_PIN,
    output logic             O_FAST_LINK_FAILURE_PIN_OE,
    // Serial mux configuration outputs
    output logic [1:0]       O_MAC_MODE,
    output logic [7:0]       O_ADDR_BYTE,
    output logic [3:0]       O_MUX_PORT_ACTIVE,
    output logic [3:0]       O_MUX_SCL
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    mmsm_pkg::mmsm_mac_mode_type mac_mode_r;
    logic [3:0]             fl_src_r;
    logic [6:0]             dev_addr_r;
    mmsm_pkg::mmsm_scl_sel_type scl_sel_r;
    logic [3:0]             port_en_r;
    logic                   dir_r;
    mmsm_pkg::mmsm_apb_state_type apb_st_r;
    mmsm_pkg::mmsm_apb_state_type apb_st_nxt;
    logic [31:0]            prdata_r;
    logic                   pready_r;
    logic                   pslverr_r;
    logic [3:0]             fail_s1_r;
    logic [3:0]             fail_s2_r;
    logic                   led_s1_r;
    logic                   led_s2_r;
    logic                   fl_pin_r;
    logic                   fl_oe_r;
    logic [7:0]             addr_byte_r;
    logic [3:0]             active_r;
    logic [3:0]             scl_out_r;
    logic                   scl;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire        setup     = I_PSEL && !I_PENABLE;
    wire        hit_mac   = (I_PADDR == `MMSM_ADDR_MACCFG);
    wire        hit_mux   = (I_PADDR == `MMSM_ADDR_MUXSETUP);
    wire        hit_ctl   = (I_PADDR == `MMSM_ADDR_MUXCTRL);
    wire        mapped    = hit_mac || hit_mux || hit_ctl;
    wire        wr_go     = setup && I_PWRITE && mapped;
    wire        lo_en     = I_PSTRB[0];
    wire        hi_en     = I_PSTRB[1];
    wire [15:0] wd        = I_PWDATA[15:0];

    // Reserved bits left out of every image, so reads give zero
    wire [15:0] rd_mac = {mac_mode_r, 10'h000, fl_src_r};
    wire [15:0] rd_mux = {dev_addr_r, 3'h0, scl_sel_r,
                          port_en_r};
    wire [15:0] rd_ctl = {7'h00, dir_r, 8'h00};
    wire [15:0] rd_sel = hit_mac ? rd_mac :
                         hit_mux ? rd_mux :
                         hit_ctl ? rd_ctl : 16'h0000;

    // No wait state: setup captures, first access cycle answers
    always_comb begin
        case (apb_st_r)
            mmsm_pkg::MMSM_APB_IDLE:
                apb_st_nxt = setup ? mmsm_pkg::MMSM_APB_ACCESS
                                   : mmsm_pkg::MMSM_APB_IDLE;
            default: apb_st_nxt = mmsm_pkg::MMSM_APB_IDLE;
        endcase
    end

    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            apb_st_r  <= mmsm_pkg::MMSM_APB_IDLE;
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            apb_st_r  <= apb_st_nxt;
            // Ready marks the access cycle that the state enters
            pready_r  <= (apb_st_nxt == mmsm_pkg::MMSM_APB_ACCESS);
            pslverr_r <= setup && !mapped;
            if (setup) begin
                prdata_r <= I_PWRITE ? 32'h0000_0000 : {16'h0000, rd_sel};
            end
        end
    end

    // ------------------------------------------------------------
    // Register writes (taken in setup, visible at the answer)
    // ------------------------------------------------------------
    // Strobes gate each byte, so a low-byte write keeps the address
    wire        wr_mac_hi = wr_go && hit_mac && hi_en;
    wire        wr_mac_lo = wr_go && hit_mac && lo_en;
    wire        wr_mux_hi = wr_go && hit_mux && hi_en;
    wire        wr_mux_lo = wr_go && hit_mux && lo_en;
    wire        wr_ctl_hi = wr_go && hit_ctl && hi_en;

    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            mac_mode_r <= mmsm_pkg::mmsm_mac_mode_type'(`MMSM_MACMODE_RST);
            fl_src_r   <= `MMSM_FLSRC_RST;
            dev_addr_r <= `MMSM_DEVADDR_RST;
            scl_sel_r  <= mmsm_pkg::mmsm_scl_sel_type'(`MMSM_SCLSEL_RST);
            port_en_r  <= `MMSM_PORTEN_RST;
            dir_r      <= `MMSM_DIR_RST;
        end else begin
            if (wr_mac_hi) begin
                mac_mode_r <= mmsm_pkg::mmsm_mac_mode_type'(
                    wd[`MMSM_MACMODE_LSB +: 2]);
            end
            if (wr_mac_lo) begin
                fl_src_r <= wd[`MMSM_FLSRC_LSB +: 4];
            end
            if (wr_mux_hi) begin
                dev_addr_r <= wd[`MMSM_DEVADDR_LSB +: 7];
            end
            if (wr_mux_lo) begin
                scl_sel_r <= mmsm_pkg::mmsm_scl_sel_type'(
                    wd[`MMSM_SCLSEL_LSB +: 2]);
                port_en_r <= wd[`MMSM_PORTEN_LSB +: 4];
            end
            if (wr_ctl_hi) begin
                dir_r <= wd[`MMSM_DIR_LSB];
            end
        end
    end

    // ------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            fail_s1_r <= 4'h0;
            fail_s2_r <= 4'h0;
            led_s1_r  <= 1'b0;
            led_s2_r  <= 1'b0;
        end else begin
            fail_s1_r <= I_PORT_LINK_FAIL;
            fail_s2_r <= fail_s1_r;
            led_s1_r  <= I_SERIAL_LED_EN;
            led_s2_r  <= led_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Derived outputs
    // ------------------------------------------------------------
    // Codes 0100-1011 are undefined; treated as disabled for safety
    wire       fl_valid = (fl_src_r[3:2] == 2'h0);
    wire       fl_sel   = fail_s2_r[fl_src_r[1:0]];
    wire       fl_drive = fl_valid & fl_sel;
    wire [3:0] active   = {port_en_r[3:1],
                           port_en_r[0] & ~led_s2_r};
    // Idle high on disabled ports, like a released bus
    wire [3:0] scl_pins = ~active | {4{scl}};

    mmsm_scl_div u_scl_div (
        .i_clk   (I_MCLK),
        .i_rst_b (I_RST_B),
        .i_sel   (scl_sel_r),
        .o_scl   (scl)
    );

    always_ff @(posedge I_MCLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            fl_pin_r    <= 1'b0;
            fl_oe_r     <= 1'b0;
            addr_byte_r <= 8'h00;
            active_r    <= 4'h0;
            scl_out_r   <= 4'hf;
        end else begin
            fl_pin_r    <= fl_drive;
            fl_oe_r     <= fl_valid;
            addr_byte_r <= {dev_addr_r, dir_r};
            active_r    <= active;
            scl_out_r   <= scl_pins;
        end
    end

    assign O_PRDATA                   = prdata_r;
    assign O_PREADY                   = pready_r;
    assign O_PSLVERR                  = pslverr_r;
    assign O_FAST_LINK_FAILURE_PIN    = fl_pin_r;
    assign O_FAST_LINK_FAILURE_PIN_OE = fl_oe_r;
    assign O_MAC_MODE                 = mac_mode_r;
    assign O_ADDR_BYTE                = addr_byte_r;
    assign O_MUX_PORT_ACTIVE          = active_r;
    assign O_MUX_SCL                  = scl_out_r;

endmodule

// [sim/mmsm_assertions.sv]
// Purpose: Port-level checks on the configuration block
// Assumes: Bound to mmsm_top; one clock domain
// Notes:   Write latencies follow the registered pin outputs
`timescale 1ns/1ps
module mmsm_assertions (
    // Clock, reset and bus
    input wire logic        I_MCLK,
    input wire logic        I_RST_B,
    input wire logic        I_PSEL,
    input wire logic        I_PENABLE,
    input wire logic        I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0]  I_PSTRB,
    input wire logic [31:0] O_PRDATA,
    input wire logic        O_PREADY,
    input wire logic        O_PSLVERR,
    // Pins
    input wire logic        I_SERIAL_LED_EN,
    input wire logic        O_FAST_LINK_FAILURE_PIN,
    input wire logic        O_FAST_LINK_FAILURE_PIN_OE,
    input wire logic [1:0]  O_MAC_MODE,
    input wire logic [7:0]  O_ADDR_BYTE,
    input wire logic [3:0]  O_MUX_PORT_ACTIVE,
    input wire logic [3:0]  O_MUX_SCL
);
    // ------------------------------------------------------------
    // Write decodes
    // ------------------------------------------------------------
    wire su   = I_PSEL && !I_PENABLE;
    wire w_hi = su && I_PWRITE && I_PSTRB[1];
    wire w_lo = su && I_PWRITE && I_PSTRB[0];
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_B);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_READY: assert property (su |=> O_PREADY ##1 !O_PREADY)
        else $error("ready not a single answer cycle");
    AST_ERR: assert property (
        O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0)
        else $error("error answer not zero");
    AST_HI: assert property (
        O_PREADY |-> O_PRDATA[31:16] == 16'h0)
        else $error("upper read half not zero");
    AST_MODE: assert property (w_hi && I_PADDR == 12'h04c
        |=> O_MAC_MODE == $past(I_PWDATA[15:14])) else $error("mac mode");
    AST_OE: assert property (w_lo && I_PADDR == 12'h04c
        |=> ##1 O_FAST_LINK_FAILURE_PIN_OE ==
            ($past(I_PWDATA[3:0], 2) < 4'h4))
        else $error("fail pin enable");
    AST_PIN: assert property (!O_FAST_LINK_FAILURE_PIN_OE
        |-> !O_FAST_LINK_FAILURE_PIN) else $error("pin driven while off");
    AST_DEV: assert property (w_hi && I_PADDR == 12'h050
        |=> ##1 O_ADDR_BYTE[7:1] == $past(I_PWDATA[15:9], 2))
        else $error("device address");
    AST_DIR: assert property (w_hi && I_PADDR == 12'h054
        |=> ##1 O_ADDR_BYTE[0] == $past(I_PWDATA[8], 2))
        else $error("direction bit");
    AST_LED: assert property (
        I_SERIAL_LED_EN[*4] |-> !O_MUX_PORT_ACTIVE[0])
        else $error("port 0 active under led");
    AST_IDLE: assert property (
        (O_MUX_SCL | O_MUX_PORT_ACTIVE) == 4'hf)
        else $error("idle port clock low");
endmodule

// [sim/mmsm_port_model.sv]
// Purpose: Far-side status pins of the four ports
// Assumes: Driven from the bench through its task
// Notes:   Moves only just after a clock edge
`timescale 1ns/1ps
module mmsm_port_model (
    input  wire logic       i_clk,
    output logic      [3:0] o_link_fail,
    output logic            o_led_en
);
    initial begin
        o_link_fail = 4'h0;
        o_led_en    = 1'b0;
    end
    // Pins are asynchronous to the block; edge-aligned keeps runs stable
    task automatic drive(input logic [3:0] f, input logic l);
        @(posedge i_clk);
        o_link_fail <= f;
        o_led_en    <= l;
    endtask
endmodule

// [sim/tb_mac_mode_serial_mux_config.sv]
// Purpose: Register and pin tests of the configuration block
// Assumes: Zero-wait APB slave, 200 MHz clock
// Notes:   SCL half periods measured on port 0 only
`timescale 1ns/1ps
module tb_mac_mode_serial_mux_config;
    logic        mclk, rst_b, psel, pen, pwr, err, pin, oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, fail, act, scl;
    logic [1:0]  mode;
    logic [7:0]  ab;
    logic        led, rdy;
    int          fail_count, checked, i, n;
    mmsm_port_model u_ports (.i_clk(mclk), .o_link_fail(fail), .o_led_en(led));
    mmsm_top DUT (.I_MCLK(mclk), .I_RST_B(rst_b), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(rdy), .O_PSLVERR(err),
        .I_PORT_LINK_FAIL(fail), .I_SERIAL_LED_EN(led),
        .O_FAST_LINK_FAILURE_PIN(pin), .O_FAST_LINK_FAILURE_PIN_OE(oe),
        .O_MAC_MODE(mode), .O_ADDR_BYTE(ab), .O_MUX_PORT_ACTIVE(act),
        .O_MUX_SCL(scl));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Holds the request until ready is sampled, then releases
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int k;
        @(posedge mclk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        pstrb  <= w ? s : 4'h0;
        @(posedge mclk);
        pen <= 1'b1;
        for (k = 0; k < 20 && rdy !== 1'b1; k++) begin
            @(posedge mclk);
        end
        if (k == 20) begin
            fail_count++;
            report_and_stop();
        end
        rd = prdata;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask
    // Three changes: the first may be the port waking up, the second
    // may close a phase cut short by the rate change
    task automatic scl_gap(output int m);
        logic v;
        for (int j = 0; j < 3; j++) begin
            m = 0;
            v = scl[0];
            while (scl[0] === v && m < 5000) begin
                @(posedge mclk);
                m++;
            end
            if (m == 5000) begin
                fail_count++;
                report_and_stop();
            end
        end
    endtask
    logic [11:0] adr [3] = '{12'h04c, 12'h050, 12'h054};
    logic [15:0] rst [3] = '{16'h000f, 16'ha010, 16'h0100};
    logic [15:0] msk [3] = '{16'hc00f, 16'hfe3f, 16'h0100};
    // Half periods in clocks at 200 MHz
    int          half [4] = '{2000, 1000, 250, 50};
    initial begin
        {fail_count, checked} = 0;
        {rst_b, psel, pen, pwr, paddr, pwdata, pstrb} = 0;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        check(ab, 8'ha1);
        for (i = 0; i < 3; i++) begin
            apb(0, adr[i], 0, 0);
            check(rd, rst[i]);
            apb(1, adr[i], 32'hffffffff, 4'hf);
            apb(0, adr[i], 0, 0);
            check(rd, msk[i]);
        end
        apb(1, 12'h050, 0, 4'h1);
        apb(0, 12'h050, 0, 0);
        check(rd, 32'hfe00);
        apb(0, 12'h058, 0, 0);
        check({rd[30:0], err}, 1);
        $display("test registers done");
        for (i = 0; i < 2; i++) begin
            apb(1, 12'h04c, i << 14, 4'h2);
            check(mode, i);
        end
        apb(1, 12'h050, 32'h5400, 4'h2);
        apb(1, 12'h054, 0, 4'h2);
        @(posedge mclk);
        check(ab, 8'h54);
        $display("test address byte done");
        for (i = 0; i < 6; i++) begin
            apb(1, 12'h04c, i < 4 ? i : 8 * i - 28, 4'h1);
            u_ports.drive(4'h1 << i, 0);
            repeat (5) @(posedge mclk);
            check({oe, pin}, i < 4 ? 2'h3 : 2'h0);
            u_ports.drive(~(4'h1 << i), 0);
            repeat (5) @(posedge mclk);
            check({oe, pin}, i < 4 ? 2'h2 : 2'h0);
        end
        $display("test fail pin done");
        for (i = 0; i < 4; i++) begin
            apb(1, 12'h050, 32'ha001 | (i << 4), 4'h3);
            scl_gap(n);
            check({act, scl[3:1]}, 7'h0f);
            check(n >= half[i] - 1 && n <= half[i] + 1, 1);
        end
        u_ports.drive(0, 1);
        apb(1, 12'h050, 32'ha01f, 4'h3);
        repeat (5) @(posedge mclk);
        check(act, 4'he);
        u_ports.drive(0, 0);
        repeat (5) @(posedge mclk);
        check(act, 4'hf);
        $display("test serial mux done");
        report_and_stop();
    end
endmodule
bind mmsm_top mmsm_assertions u_ast (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
    .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .I_PSTRB(I_PSTRB),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
    .I_SERIAL_LED_EN(I_SERIAL_LED_EN), .O_MAC_MODE(O_MAC_MODE),
    .O_FAST_LINK_FAILURE_PIN(O_FAST_LINK_FAILURE_PIN),
    .O_FAST_LINK_FAILURE_PIN_OE(O_FAST_LINK_FAILURE_PIN_OE),
    .O_ADDR_BYTE(O_ADDR_BYTE), .O_MUX_PORT_ACTIVE(O_MUX_PORT_ACTIVE),
    .O_MUX_SCL(O_MUX_SCL));
